// ==== rtl/lsc_pkg.sv ====
// Behaviour
// - bus traffic is seen and answered only while module select is low.
// - reset held low past the minimum length restores all default settings.
// - on reset completion raise attention and clear the data-not-ready flag.
// - after power-up the same completion attention is raised without a pulse.
// - an undriven power-up control select input reads high.
// - select high keeps low power until software enables high power.
// - select low enters high power once management initialisation finishes.
// - an inserted module ties the presence line low.
// - attention is driven low for a fault or a pending reset completion.
// - attention is open collector: pulls low or releases, never drives high.
package lsc_pkg;

   // =========================================================================
   // timing
   localparam int CLK_PERIOD_NS      = 10;
   localparam int MIN_RESET_PULSE_NS = 10000;
   // least time, so round up
   localparam int MIN_RESET_CYCLES   =
      (MIN_RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_CNT_W          = 16;

   // =========================================================================
   // synchronised pin bundle, bit positions
   localparam int PIN_SDA  = 0;
   localparam int PIN_SCL  = 1;
   localparam int PIN_INIT = 2;
   localparam int PIN_RST  = 3;
   localparam int PIN_SEL  = 4;
   localparam int PIN_W    = 5;

   // =========================================================================
   // reset values
   localparam logic [PIN_W-1:0] PINS_IDLE = 5'h1F;
   localparam logic HP_ENABLE_RST  = 1'b0;
   localparam logic DNR_RST        = 1'b1;
   localparam logic DONE_EVT_RST   = 1'b0;
   localparam logic RELEASE_N      = 1'b1;
   localparam logic PULL_LOW       = 1'b0;
   localparam logic INIT_UNDRIVEN  = 1'b1;

   typedef enum logic [1:0]
   {
      ST_BOOT  = 2'h0,
      ST_RESET = 2'h1,
      ST_INIT  = 2'h2,
      ST_READY = 2'h3
   } lsc_state_type;

   typedef struct packed
   {
      logic sel_n;
      logic rst_n;
      logic init_sel;
      logic scl;
      logic sda;
   } lsc_pins_type;

   typedef struct packed
   {
      logic start;
      logic stop;
      logic bit_valid;
      logic bit_val;
      logic abort;
   } lsc_bus_ev_type;

   function automatic logic lsc_rise(input logic prev, input logic cur);
      lsc_rise = ~prev & cur;
   endfunction

   function automatic logic lsc_fall(input logic prev, input logic cur);
      lsc_fall = prev & ~cur;
   endfunction

endpackage

// ==== rtl/lsc_sync2.sv ====
`timescale 1ns/1ps
module lsc_sync2
#(
   parameter int               WIDTH    = 1,
   parameter logic [WIDTH-1:0] RST_VAL  = '0
)
(
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);

   // =========================================================================
   // two-stage synchroniser; first stage read only by the second
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] q_r;
   logic [WIDTH-1:0] q_nxt;

   always_comb
   begin
      meta_nxt = d_in;
      q_nxt    = meta_r;
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         meta_r <= RST_VAL;
         q_r    <= RST_VAL;
      end
      else
      begin
         meta_r <= meta_nxt;
         q_r    <= q_nxt;
      end
   end

   assign q_out = q_r;

endmodule

// ==== rtl/lsc_lowspeed_ctrl.sv ====
`timescale 1ns/1ps
module lsc_lowspeed_ctrl
#(
   parameter int MIN_RESET_CYCLES_P = lsc_pkg::MIN_RESET_CYCLES
)
(
   input  wire logic CORE_CLK_IN,
   input  wire logic RST_IN,
   // host pins
   input  wire logic MODULE_SELECT_N_IN,
   input  wire logic MODULE_RESET_N_IN,
   input  wire logic POWER_UP_CONTROL_SELECT_IN,
   input  wire logic POWER_UP_CONTROL_SELECT_DRIVEN_IN,
   input  wire logic SCL_IN,
   input  wire logic SDA_IN,
   output logic      SDA_OUT,
   output logic      SDA_OE_N_OUT,
   output logic      PRESENCE_DETECT_N_OUT,
   output logic      PRESENCE_DETECT_N_OE_N_OUT,
   output logic      ATTENTION_N_OUT,
   output logic      ATTENTION_N_OE_N_OUT,
   // management core side
   input  wire logic MGMT_SDA_LOW_IN,
   input  wire logic MGMT_INIT_DONE_IN,
   input  wire logic MGMT_HP_WRITE_IN,
   input  wire logic MGMT_HP_DATA_IN,
   input  wire logic MGMT_FAULT_IN,
   input  wire logic MGMT_DONE_CLEAR_IN,
   output logic      BUS_START_OUT,
   output logic      BUS_STOP_OUT,
   output logic      BUS_BIT_VALID_OUT,
   output logic      BUS_BIT_OUT,
   output logic      BUS_ABORT_OUT,
   output logic      MGMT_RESTORE_DEFAULTS_OUT,
   output logic      DATA_NOT_READY_OUT,
   output logic      HIGH_POWER_MODE_OUT,
   output logic      RESET_DONE_EVENT_OUT
);

   import lsc_pkg::*;

   // =========================================================================
   // pin synchronisation
   logic [PIN_W-1:0] raw_pins;
   logic [PIN_W-1:0] sync_pins;
   logic             init_eff;
   lsc_pins_type     pins;

   // undriven input floats to the internal pull-up
   assign init_eff = POWER_UP_CONTROL_SELECT_DRIVEN_IN ?
                     POWER_UP_CONTROL_SELECT_IN : INIT_UNDRIVEN;

   always_comb
   begin
      raw_pins           = '0;
      raw_pins[PIN_SEL]  = MODULE_SELECT_N_IN;
      raw_pins[PIN_RST]  = MODULE_RESET_N_IN;
      raw_pins[PIN_INIT] = init_eff;
      raw_pins[PIN_SCL]  = SCL_IN;
      raw_pins[PIN_SDA]  = SDA_IN;
   end

   lsc_sync2
   #(
      .WIDTH   (PIN_W),
      .RST_VAL (PINS_IDLE)
   )
   u_sync
   (
      .clk_in (CORE_CLK_IN),
      .rst_in (RST_IN),
      .d_in   (raw_pins),
      .q_out  (sync_pins)
   );

   assign pins = lsc_pins_type'(sync_pins);

   // =========================================================================
   // 2-wire bus front end, gated by module select
   logic           scl_d_r;
   logic           scl_d_nxt;
   logic           sda_d_r;
   logic           sda_d_nxt;
   logic           xfer_r;
   logic           xfer_nxt;
   lsc_bus_ev_type ev_r;
   lsc_bus_ev_type ev_nxt;
   logic           sda_oe_n_r;
   logic           sda_oe_n_nxt;
   logic           selected;

   assign selected = ~pins.sel_n;

   always_comb
   begin
      scl_d_nxt    = pins.scl;
      sda_d_nxt    = pins.sda;
      xfer_nxt     = xfer_r;
      ev_nxt       = '0;
      sda_oe_n_nxt = RELEASE_N;
      if (selected)
      begin
         if (pins.scl && lsc_fall(sda_d_r, pins.sda))
         begin
            ev_nxt.start = 1'b1;
            xfer_nxt     = 1'b1;
         end
         else if (pins.scl && lsc_rise(sda_d_r, pins.sda))
         begin
            ev_nxt.stop = 1'b1;
            xfer_nxt    = 1'b0;
         end
         else if (xfer_r && lsc_rise(scl_d_r, pins.scl))
         begin
            ev_nxt.bit_valid = 1'b1;
            ev_nxt.bit_val   = pins.sda;
         end
         // only pull the data line while addressed
         sda_oe_n_nxt = ~MGMT_SDA_LOW_IN;
      end
      else if (xfer_r)
      begin
         // deselected mid-transfer: drop it so the core resynchronises
         ev_nxt.abort = 1'b1;
         xfer_nxt     = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         scl_d_r    <= 1'b1;
         sda_d_r    <= 1'b1;
         xfer_r     <= 1'b0;
         ev_r       <= '0;
         sda_oe_n_r <= RELEASE_N;
      end
      else
      begin
         scl_d_r    <= scl_d_nxt;
         sda_d_r    <= sda_d_nxt;
         xfer_r     <= xfer_nxt;
         ev_r       <= ev_nxt;
         sda_oe_n_r <= sda_oe_n_nxt;
      end
   end

   // =========================================================================
   // module reset qualification and power-up sequencing
   logic [RST_CNT_W-1:0] cnt_r;
   logic [RST_CNT_W-1:0] cnt_nxt;
   lsc_state_type        state_r;
   lsc_state_type        state_nxt;
   logic                 hp_en_r;
   logic                 hp_en_nxt;
   logic                 dnr_r;
   logic                 dnr_nxt;
   logic                 hp_mode_r;
   logic                 hp_mode_nxt;
   logic                 restore_r;
   logic                 restore_nxt;
   logic                 done_pulse;
   logic                 rst_qual;

   // strictly longer than the minimum, anything shorter is a glitch
   assign rst_qual = ~pins.rst_n &&
                     (cnt_r == RST_CNT_W'(MIN_RESET_CYCLES_P));

   always_comb
   begin
      cnt_nxt     = '0;
      state_nxt   = state_r;
      hp_en_nxt   = hp_en_r;
      dnr_nxt     = dnr_r;
      restore_nxt = 1'b0;
      done_pulse  = 1'b0;
      if (!pins.rst_n && !rst_qual)
      begin
         cnt_nxt = cnt_r + RST_CNT_W'(1);
      end
      else if (rst_qual)
      begin
         cnt_nxt = cnt_r;
      end
      case (state_r)
         ST_BOOT:
         begin
            // power-up runs the same path as a pin reset
            restore_nxt = 1'b1;
            state_nxt   = ST_INIT;
         end
         ST_RESET:
         begin
            restore_nxt = 1'b1;
            hp_en_nxt   = HP_ENABLE_RST;
            dnr_nxt     = DNR_RST;
            if (pins.rst_n)
            begin
               state_nxt = ST_INIT;
            end
         end
         ST_INIT:
         begin
            if (MGMT_INIT_DONE_IN)
            begin
               dnr_nxt    = 1'b0;
               done_pulse = 1'b1;
               state_nxt  = ST_READY;
            end
         end
         ST_READY:
         begin
            if (MGMT_HP_WRITE_IN)
            begin
               hp_en_nxt = MGMT_HP_DATA_IN;
            end
         end
         default:
         begin
            state_nxt = ST_BOOT;
         end
      endcase
      if (rst_qual)
      begin
         state_nxt   = ST_RESET;
         restore_nxt = 1'b1;
         hp_en_nxt   = HP_ENABLE_RST;
         dnr_nxt     = DNR_RST;
         done_pulse  = 1'b0;
      end
      hp_mode_nxt = 1'b0;
      if (state_nxt == ST_READY)
      begin
         if (pins.init_sel)
         begin
            hp_mode_nxt = hp_en_nxt;
         end
         else
         begin
            hp_mode_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         cnt_r     <= '0;
         state_r   <= ST_BOOT;
         hp_en_r   <= HP_ENABLE_RST;
         dnr_r     <= DNR_RST;
         hp_mode_r <= 1'b0;
         restore_r <= 1'b1;
      end
      else
      begin
         cnt_r     <= cnt_nxt;
         state_r   <= state_nxt;
         hp_en_r   <= hp_en_nxt;
         dnr_r     <= dnr_nxt;
         hp_mode_r <= hp_mode_nxt;
         restore_r <= restore_nxt;
      end
   end

   // =========================================================================
   // attention and presence
   logic done_evt_r;
   logic done_evt_nxt;
   logic attn_oe_n_r;
   logic attn_oe_n_nxt;
   logic pres_oe_n_r;
   logic pres_oe_n_nxt;
   logic zero_r;
   logic zero_nxt;

   always_comb
   begin
      done_evt_nxt = done_evt_r;
      if (MGMT_DONE_CLEAR_IN)
      begin
         done_evt_nxt = 1'b0;
      end
      // a completion in the clearing cycle must not be lost
      if (done_pulse)
      begin
         done_evt_nxt = 1'b1;
      end
      if (rst_qual)
      begin
         done_evt_nxt = DONE_EVT_RST;
      end
      // pull low or release only, the host owns the pull-up
      attn_oe_n_nxt = ~(done_evt_nxt | MGMT_FAULT_IN);
      pres_oe_n_nxt = PULL_LOW;
      zero_nxt      = 1'b0;
   end

   always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         done_evt_r  <= DONE_EVT_RST;
         attn_oe_n_r <= RELEASE_N;
         pres_oe_n_r <= PULL_LOW;
         zero_r      <= 1'b0;
      end
      else
      begin
         done_evt_r  <= done_evt_nxt;
         attn_oe_n_r <= attn_oe_n_nxt;
         pres_oe_n_r <= pres_oe_n_nxt;
         zero_r      <= zero_nxt;
      end
   end

   // =========================================================================
   // outputs; open-drain data values are constant low flops
   assign SDA_OUT                    = zero_r;
   assign SDA_OE_N_OUT               = sda_oe_n_r;
   assign PRESENCE_DETECT_N_OUT      = zero_r;
   assign PRESENCE_DETECT_N_OE_N_OUT = pres_oe_n_r;
   assign ATTENTION_N_OUT            = zero_r;
   assign ATTENTION_N_OE_N_OUT       = attn_oe_n_r;
   assign BUS_START_OUT              = ev_r.start;
   assign BUS_STOP_OUT               = ev_r.stop;
   assign BUS_BIT_VALID_OUT          = ev_r.bit_valid;
   assign BUS_BIT_OUT                = ev_r.bit_val;
   assign BUS_ABORT_OUT              = ev_r.abort;
   assign MGMT_RESTORE_DEFAULTS_OUT  = restore_r;
   assign DATA_NOT_READY_OUT         = dnr_r;
   assign HIGH_POWER_MODE_OUT        = hp_mode_r;
   assign RESET_DONE_EVENT_OUT       = done_evt_r;

endmodule

// ==== bench/lsc_lowspeed_ctrl_checker.sv ====
`timescale 1ns/1ps
module lsc_lowspeed_ctrl_checker
#(
   parameter int MIN_RESET_CYCLES_P = lsc_pkg::MIN_RESET_CYCLES
)
(
   input wire logic CORE_CLK_IN,
   input wire logic RST_IN,
   input wire logic MODULE_SELECT_N_IN,
   input wire logic MODULE_RESET_N_IN,
   input wire logic POWER_UP_CONTROL_SELECT_IN,
   input wire logic POWER_UP_CONTROL_SELECT_DRIVEN_IN,
   input wire logic MGMT_FAULT_IN,
   input wire logic MGMT_HP_WRITE_IN,
   input wire logic SDA_OE_N_OUT,
   input wire logic PRESENCE_DETECT_N_OUT,
   input wire logic PRESENCE_DETECT_N_OE_N_OUT,
   input wire logic ATTENTION_N_OUT,
   input wire logic ATTENTION_N_OE_N_OUT,
   input wire logic BUS_START_OUT,
   input wire logic MGMT_RESTORE_DEFAULTS_OUT,
   input wire logic DATA_NOT_READY_OUT,
   input wire logic HIGH_POWER_MODE_OUT,
   input wire logic RESET_DONE_EVENT_OUT
);
   logic [15:0] lo_r;
   logic [15:0] lo_nxt;
   logic        sw_mode;

   // =====================================================================
   // raw reset pin low run, no sync so the count leads the design
   always_comb
   begin
      lo_nxt = MODULE_RESET_N_IN ? 16'h0000 : lo_r + 16'h0001;
   end

   always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
         lo_r <= 16'h0000;
      else
         lo_r <= lo_nxt;
   end

   // undriven select reads high
   assign sw_mode = POWER_UP_CONTROL_SELECT_IN
                    | ~POWER_UP_CONTROL_SELECT_DRIVEN_IN;

   // =====================================================================
   // properties
   default clocking cb @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (RST_IN);

   property p_sel_sda;
      MODULE_SELECT_N_IN [*5] |-> SDA_OE_N_OUT;
   endproperty
   a_sel_sda: assert property (p_sel_sda)
      else $error("sda pulled while deselected");

   property p_sel_quiet;
      MODULE_SELECT_N_IN [*5] |-> !BUS_START_OUT;
   endproperty
   a_sel_quiet: assert property (p_sel_quiet)
      else $error("start reported while deselected");

   property p_pres;
      !PRESENCE_DETECT_N_OE_N_OUT && !PRESENCE_DETECT_N_OUT;
   endproperty
   a_pres: assert property (p_pres)
      else $error("presence not tied low");

   property p_od;
      ATTENTION_N_OUT == 1'b0;
   endproperty
   a_od: assert property (p_od)
      else $error("attention drives high");

   property p_done;
      $rose(RESET_DONE_EVENT_OUT)
         |-> !DATA_NOT_READY_OUT && !ATTENTION_N_OE_N_OUT;
   endproperty
   a_done: assert property (p_done)
      else $error("completion without attention or ready");

   property p_fault;
      MGMT_FAULT_IN [*2] |-> !ATTENTION_N_OE_N_OUT;
   endproperty
   a_fault: assert property (p_fault)
      else $error("fault not flagged");

   property p_sw;
      $rose(HIGH_POWER_MODE_OUT) && sw_mode |-> $past(MGMT_HP_WRITE_IN);
   endproperty
   a_sw: assert property (p_sw)
      else $error("high power without software enable");

   property p_hw;
      $fell(DATA_NOT_READY_OUT) && !sw_mode |-> HIGH_POWER_MODE_OUT;
   endproperty
   a_hw: assert property (p_hw)
      else $error("hardware mode did not enter high power");

   property p_short;
      $rose(MGMT_RESTORE_DEFAULTS_OUT) |-> lo_r > MIN_RESET_CYCLES_P;
   endproperty
   a_short: assert property (p_short)
      else $error("short reset pulse accepted");

   property p_long;
      lo_r == MIN_RESET_CYCLES_P + 5
         |-> MGMT_RESTORE_DEFAULTS_OUT && DATA_NOT_READY_OUT
             && !RESET_DONE_EVENT_OUT;
   endproperty
   a_long: assert property (p_long)
      else $error("long reset pulse not taken");

   c_done: cover property ($rose(RESET_DONE_EVENT_OUT));
   c_start: cover property (BUS_START_OUT);
   c_restore: cover property ($rose(MGMT_RESTORE_DEFAULTS_OUT));
endmodule

bind lsc_lowspeed_ctrl lsc_lowspeed_ctrl_checker
   #(.MIN_RESET_CYCLES_P(MIN_RESET_CYCLES_P)) i_chk
   (
      .CORE_CLK_IN                       (CORE_CLK_IN),
      .RST_IN                            (RST_IN),
      .MODULE_SELECT_N_IN                (MODULE_SELECT_N_IN),
      .MODULE_RESET_N_IN                 (MODULE_RESET_N_IN),
      .POWER_UP_CONTROL_SELECT_IN        (POWER_UP_CONTROL_SELECT_IN),
      .POWER_UP_CONTROL_SELECT_DRIVEN_IN (POWER_UP_CONTROL_SELECT_DRIVEN_IN),
      .MGMT_FAULT_IN                     (MGMT_FAULT_IN),
      .MGMT_HP_WRITE_IN                  (MGMT_HP_WRITE_IN),
      .SDA_OE_N_OUT                      (SDA_OE_N_OUT),
      .PRESENCE_DETECT_N_OUT             (PRESENCE_DETECT_N_OUT),
      .PRESENCE_DETECT_N_OE_N_OUT        (PRESENCE_DETECT_N_OE_N_OUT),
      .ATTENTION_N_OUT                   (ATTENTION_N_OUT),
      .ATTENTION_N_OE_N_OUT              (ATTENTION_N_OE_N_OUT),
      .BUS_START_OUT                     (BUS_START_OUT),
      .MGMT_RESTORE_DEFAULTS_OUT         (MGMT_RESTORE_DEFAULTS_OUT),
      .DATA_NOT_READY_OUT                (DATA_NOT_READY_OUT),
      .HIGH_POWER_MODE_OUT               (HIGH_POWER_MODE_OUT),
      .RESET_DONE_EVENT_OUT              (RESET_DONE_EVENT_OUT)
   );

// ==== bench/lsc_host_model.sv ====
`timescale 1ns/1ps
module lsc_host_model
(
   output logic scl_out,
   output logic sda_low_out
);
   localparam time HALF = 80ns;
   localparam time QTR  = 40ns;

   // clock stands high between frames
   initial
   begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end

   // =====================================================================
   // start, msb-first bits, stop; data moves only while clock is low
   task automatic frame(input logic [3:0] bits);
      int i;
      sda_low_out = 1'b1;
      #(HALF);
      for (i = 3; i >= 0; i--)
      begin
         scl_out = 1'b0;
         #(QTR);
         sda_low_out = ~bits[i];
         #(QTR);
         scl_out = 1'b1;
         #(HALF);
      end
      scl_out = 1'b0;
      #(QTR);
      sda_low_out = 1'b1;
      #(QTR);
      scl_out = 1'b1;
      #(HALF);
      sda_low_out = 1'b0;
      #(HALF);
   endtask
endmodule

// ==== bench/lsc_lowspeed_ctrl_tb.sv ====
`timescale 1ns/1ps
module lsc_lowspeed_ctrl_tb;
   import lsc_pkg::*;
   localparam int MIN_P = 8;
   logic clk = 1'b0, rst = 1'b1, sel_n = 1'b1, mrst_n = 1'b1;
   logic pucs = 1'b0, pucs_drv = 1'b0, msda = 1'b0, idone = 1'b0;
   logic hp_wr = 1'b0, fault = 1'b0, dclr = 1'b0, hp_dat = 1'b1;
   logic scl, host_low, sda_oe_n, pres, pres_oe_n, attn, attn_oe_n, sda_o;
   logic b_start, b_stop, b_bv, b_bit, b_abort, restore, dnr, hp, evt;
   wire logic sda_w;
   logic [7:0] bits_r = 8'h00;
   int n_start = 0, n_stop = 0, n_bit = 0, n_abort = 0, cycles = 0;
   int n_fail = 0, comparisons = 0;

   always #5 clk = ~clk;
   // pulled-up open-drain data line
   assign sda_w = ~(host_low | ~sda_oe_n);

   lsc_host_model i_host (.scl_out(scl), .sda_low_out(host_low));
   lsc_lowspeed_ctrl #(.MIN_RESET_CYCLES_P(MIN_P)) i_dut
   (
      .CORE_CLK_IN(clk), .RST_IN(rst), .MODULE_SELECT_N_IN(sel_n),
      .MODULE_RESET_N_IN(mrst_n), .POWER_UP_CONTROL_SELECT_IN(pucs),
      .POWER_UP_CONTROL_SELECT_DRIVEN_IN(pucs_drv), .SCL_IN(scl),
      .SDA_IN(sda_w), .SDA_OUT(sda_o), .SDA_OE_N_OUT(sda_oe_n),
      .PRESENCE_DETECT_N_OUT(pres), .PRESENCE_DETECT_N_OE_N_OUT(pres_oe_n),
      .ATTENTION_N_OUT(attn), .ATTENTION_N_OE_N_OUT(attn_oe_n),
      .MGMT_SDA_LOW_IN(msda), .MGMT_INIT_DONE_IN(idone),
      .MGMT_HP_WRITE_IN(hp_wr), .MGMT_HP_DATA_IN(hp_dat),
      .MGMT_FAULT_IN(fault), .MGMT_DONE_CLEAR_IN(dclr),
      .BUS_START_OUT(b_start), .BUS_STOP_OUT(b_stop),
      .BUS_BIT_VALID_OUT(b_bv), .BUS_BIT_OUT(b_bit),
      .BUS_ABORT_OUT(b_abort), .MGMT_RESTORE_DEFAULTS_OUT(restore),
      .DATA_NOT_READY_OUT(dnr), .HIGH_POWER_MODE_OUT(hp),
      .RESET_DONE_EVENT_OUT(evt)
   );

   // =====================================================================
   // bus event monitor and hang guard
   // sampled mid-cycle, well away from the edge that launches the pulses
   always @(negedge clk)
   begin
      if (b_start === 1'b1) n_start++;
      if (b_stop === 1'b1) n_stop++;
      if (b_abort === 1'b1) n_abort++;
      if (b_bv === 1'b1)
      begin
         n_bit++;
         bits_r <= {bits_r[6:0], b_bit};
      end
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         test_done();
      end
   end

   // =====================================================================
   // helpers
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wait_evt;
      int i;
      // host disregards status until completion is flagged
      for (i = 0; i < 60 && evt !== 1'b1; i++) tick(1);
   endtask

   task automatic test_done;
      if (n_fail == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // =====================================================================
   // scenarios
   task automatic t_power_sw;
      idone = 1'b1;
      wait_evt();
      chk(dnr, 1'b0);
      chk(attn_oe_n, 1'b0);
      chk(hp, 1'b0);
      tick(20);
      chk(hp, 1'b0);
      hp_wr = 1'b1;
      tick(1);
      chk(hp, 1'b1);
      hp_dat = 1'b0;
      tick(1);
      chk(hp, 1'b0);
      hp_dat = 1'b1;
      tick(1);
      hp_wr = 1'b0;
      chk(hp, 1'b1);
      dclr = 1'b1;
      tick(1);
      dclr = 1'b0;
      tick(1);
      chk(attn_oe_n, 1'b1);
      chk({attn, pres, pres_oe_n, sda_o}, 8'h00);
   endtask

   task automatic t_bus;
      sel_n = 1'b0;
      msda = 1'b1;
      tick(5);
      chk(sda_oe_n, 1'b0);
      // own pull with the clock idling high is a start, release a stop
      msda = 1'b0;
      tick(6);
      i_host.frame(4'hA);
      tick(5);
      // the stop's clock rise is reported as a fifth bit
      chk({8'(n_start), 8'(n_stop)}, 16'h0202);
      chk({8'(n_bit), bits_r}, 16'h0514);
      msda = 1'b1;
      sel_n = 1'b1;
      tick(5);
      chk(sda_oe_n, 1'b1);
      msda = 1'b0;
      i_host.frame(4'h5);
      tick(5);
      chk({8'(n_start), 8'(n_bit)}, 16'h0205);
      sel_n = 1'b0;
      tick(5);
      fork
         i_host.frame(4'h3);
         begin
            tick(40);
            sel_n = 1'b1;
         end
      join
      tick(5);
      chk(16'(n_abort), 16'h0001);
   endtask

   task automatic t_fault;
      fault = 1'b1;
      tick(3);
      chk(attn_oe_n, 1'b0);
      sel_n = 1'b0;
      tick(5);
      i_host.frame(4'h1);
      tick(5);
      sel_n = 1'b1;
      chk(16'(n_start), 16'h0004);
      fault = 1'b0;
      tick(3);
      chk(attn_oe_n, 1'b1);
   endtask

   task automatic t_reset_pin;
      mrst_n = 1'b0;
      tick(MIN_P);
      mrst_n = 1'b1;
      tick(8);
      chk({restore, dnr, hp}, 8'h01);
      mrst_n = 1'b0;
      tick(MIN_P + 6);
      chk({restore, dnr, hp, evt}, 8'h0C);
      mrst_n = 1'b1;
      wait_evt();
      chk({restore, dnr, attn_oe_n, evt}, 8'h01);
   endtask

   task automatic t_power_hw;
      rst = 1'b1;
      idone = 1'b0;
      pucs_drv = 1'b1;
      tick(2);
      rst = 1'b0;
      tick(6);
      idone = 1'b1;
      wait_evt();
      chk({hp, dnr}, 8'h02);
   endtask

   initial
   begin
      tick(8);
      rst = 1'b0;
      tick(5);
      t_power_sw();
      t_bus();
      t_fault();
      t_reset_pin();
      t_power_hw();
      test_done();
   end
endmodule
